/* File: src/sweep_params.svh */
/*
 * Constants of the stepped sweep controller: step rates, step size and
 * reset values.
 * Assumes a single 250 MHz system clock.
 */
`ifndef SWEEP_PARAMS_SVH
`define SWEEP_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and step timing
// ----------------------------------------------------------------------
`define CLK_KHZ 250000
`define SLOW_STEP_MS 10
`define FAST_STEP_MS 1
`define SLOW_STEP_CYCLES (`SLOW_STEP_MS * `CLK_KHZ)
`define FAST_STEP_CYCLES (`FAST_STEP_MS * `CLK_KHZ)

// ----------------------------------------------------------------------
// Frequency step and reset values
// ----------------------------------------------------------------------
`define STEP_MHZ 15'h0001
`define FREQ_RESET 15'h0000
`define RAMP_RESET 14'h0000
`define DIV_ZERO 22'h000000
`define ADDR_RESET 5'h00
`define STAT_RESET 2'h0

`endif

/* File: src/sweep_pkg.sv */
/*
 * Types shared by the stepped sweep controller files.
 * Assumes sweep_params.svh supplies the numeric constants.
 */
package sweep_pkg;
   // -------------------------------------------------------------------
   // Frequencies in MHz units
   // -------------------------------------------------------------------
   typedef logic [14:0] freq_t;
   typedef logic [13:0] span_t;
   typedef logic [15:0] sum_t;

   // -------------------------------------------------------------------
   // Modes and panel carriers
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FIXED = 2'b00,
      MODE_SLOW = 2'b01,
      MODE_FAST = 2'b10
   } mode_t;

   typedef struct packed {
      logic fixedSel;
      logic slowSel;
      logic fastSel;
      logic singleStep;
      logic returnStart;
      logic segTest;
   } panel_btn_t;

   typedef struct packed {
      logic lockGreen;
      logic levelGreen;
   } lamps_t;
endpackage

/* File: src/step_tick_gen.sv */
/*
 * Step tick divider: one pulse per slow or fast step period.
 * Assumes run and fastRate come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "sweep_params.svh"

module step_tick_gen #(
   parameter int SLOW_DIV = `SLOW_STEP_CYCLES,
   parameter int FAST_DIV = `FAST_STEP_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic fastRate,
   // Tick out
   output logic tick
);
   logic [21:0] count;
   logic lastFast;
   wire [21:0] limit = fastRate ? 22'(FAST_DIV - 1) : 22'(SLOW_DIV - 1);
   wire restart = !run || (fastRate != lastFast);
   wire atEnd = (count >= limit);

   // --------------------------------------------------------------------
   // Divider
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `DIV_ZERO;
         lastFast <= 1'b0;
         tick <= 1'b0;
      end else begin
         lastFast <= fastRate;
         count <= (restart || atEnd) ? `DIV_ZERO : count + 22'h000001;
         tick <= !restart && atEnd;
      end
   end
endmodule

/* File: src/stepped_sweep_controller.sv */
/*
 * Stepped sweep controller: mode latch, 1 MHz step sweep, manual step,
 * return to start, retrace marker, ramp value, display test, ready lamps
 * and remote address switches.
 * Assumes panel buttons, switches and status lines arrive asynchronously;
 * the synthesis loop follows outFreq.
 */
// How it works
// - Fixed mode holds output at start frequency, never sweeping.
// - Slow mode steps up 1 MHz on each 100 Hz tick.
// - Fast mode steps up 1 MHz on each 1000 Hz tick.
// - Span setting, 10 to 9999 MHz, sets distance from start to end.
// - Start setting, 100 to 26000 MHz, is fixed output and sweep origin.
// - Auto sweep counts up to start plus span, reloads start, repeats.
// - Ramp period is span plus one steps, of 10 ms slow, 1 ms fast.
// - Single step press in a step mode adds exactly 1 MHz, or nothing if it meets a step tick or return press.
// - Return press in any sweep mode reloads start frequency at once.
// - Retrace marker pulls to ground during retrace, released otherwise.
// - Holding segment test lights every display segment.
// - Lock and level lamps turn green once achieved.
// - Remote address comes from five switches as binary code.
`timescale 1ns/1ps
`include "sweep_params.svh"

module stepped_sweep_controller #(
   parameter int SLOW_DIV = `SLOW_STEP_CYCLES,
   parameter int FAST_DIV = `FAST_STEP_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Front panel
   input wire sweep_pkg::panel_btn_t buttons,
   input wire sweep_pkg::freq_t startSetting,
   input wire sweep_pkg::span_t spanSetting,
   input wire logic [4:0] addrSwitches,
   // Loop status
   input wire logic lockAchieved,
   input wire logic levelAchieved,
   // Synthesis and readout
   output sweep_pkg::freq_t outFreq,
   output sweep_pkg::freq_t frequencyReadout,
   output logic segAllOn,
   output sweep_pkg::mode_t activeMode,
   // Sweep outputs
   output sweep_pkg::span_t rampValue,
   output logic penLiftOut,
   output logic penLiftOe,
   // Status
   output sweep_pkg::lamps_t lamps,
   output logic [4:0] busAddress
);
   import sweep_pkg::*;

   // --------------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------------
   panel_btn_t btnMeta, btnSync, btnLast;
   freq_t startMeta, startSet;
   span_t spanMeta, spanSet;
   logic [4:0] addrMeta, addrSync;
   logic [1:0] statMeta, statSync;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         btnMeta <= '0;
         btnSync <= '0;
         btnLast <= '0;
         startMeta <= `FREQ_RESET;
         startSet <= `FREQ_RESET;
         spanMeta <= `RAMP_RESET;
         spanSet <= `RAMP_RESET;
         addrMeta <= `ADDR_RESET;
         addrSync <= `ADDR_RESET;
         statMeta <= `STAT_RESET;
         statSync <= `STAT_RESET;
      end else begin
         btnMeta <= buttons;
         btnSync <= btnMeta;
         btnLast <= btnSync;
         startMeta <= startSetting;
         startSet <= startMeta;
         spanMeta <= spanSetting;
         spanSet <= spanMeta;
         addrMeta <= addrSwitches;
         addrSync <= addrMeta;
         statMeta <= {lockAchieved, levelAchieved};
         statSync <= statMeta;
      end
   end

   // --------------------------------------------------------------------
   // Press detection and decode
   // --------------------------------------------------------------------
   wire panel_btn_t press = btnSync & ~btnLast;
   wire autoMode = (activeMode != MODE_FIXED);
   wire sum_t endFreq = sum_t'(startSet) + sum_t'(spanSet);
   wire atEnd = (sum_t'(outFreq) >= endFreq);
   wire stepTick;
   wire doReturn = press.returnStart && autoMode;
   mode_t next_mode;
   freq_t next_freq;
   logic next_retrace;

   always_comb begin
      next_mode = activeMode;
      if (press.fixedSel) begin
         next_mode = MODE_FIXED;
      end else if (press.slowSel) begin
         next_mode = MODE_SLOW;
      end else if (press.fastSel) begin
         next_mode = MODE_FAST;
      end
   end

   always_comb begin
      next_freq = outFreq;
      next_retrace = penLiftOe;
      if (!autoMode) begin
         next_freq = startSet;
         next_retrace = 1'b0;
      end else if (doReturn) begin
         next_freq = startSet;
         next_retrace = 1'b0;
      end else if (stepTick && atEnd) begin
         next_freq = startSet;
         next_retrace = 1'b1;
      end else if (stepTick || press.singleStep) begin
         next_freq = outFreq + `STEP_MHZ;
         next_retrace = 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Step tick divider
   // --------------------------------------------------------------------
   step_tick_gen #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV)) tickGen (
      .clk(clk),
      .rst_n(rst_n),
      .run(autoMode),
      .fastRate(activeMode == MODE_FAST),
      .tick(stepTick)
   );

   // --------------------------------------------------------------------
   // State and outputs
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         activeMode <= MODE_FIXED;
         outFreq <= `FREQ_RESET;
         frequencyReadout <= `FREQ_RESET;
         rampValue <= `RAMP_RESET;
         penLiftOut <= 1'b0;
         penLiftOe <= 1'b0;
         segAllOn <= 1'b0;
         lamps <= '0;
         busAddress <= `ADDR_RESET;
      end else begin
         activeMode <= next_mode;
         outFreq <= next_freq;
         frequencyReadout <= next_freq;
         rampValue <= span_t'(next_freq - startSet);
         penLiftOut <= 1'b0;
         penLiftOe <= next_retrace;
         segAllOn <= btnSync.segTest;
         lamps <= {statSync[1], statSync[0]};
         busAddress <= addrSync;
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence plainTick;
      stepTick && autoMode && !doReturn && !atEnd && !press.singleStep;
   endsequence

   fixed_hold_a: assert property (
      activeMode == MODE_FIXED |=> outFreq == $past(startSet))
      else $error("fixed mode did not hold start");
   slow_step_a: assert property (
      plainTick and (activeMode == MODE_SLOW) |=>
      outFreq == $past(outFreq) + `STEP_MHZ)
      else $error("slow step not 1 MHz");
   fast_step_a: assert property (
      plainTick and (activeMode == MODE_FAST) |=>
      outFreq == $past(outFreq) + `STEP_MHZ)
      else $error("fast step not 1 MHz");
   sweep_wrap_a: assert property (
      stepTick && autoMode && atEnd && !doReturn |=>
      outFreq == $past(startSet) && penLiftOe)
      else $error("sweep did not wrap to start");
   tick_space_a: assert property (
      stepTick |=> !stepTick [*8])
      else $error("step ticks too close");
   single_step_a: assert property (
      press.singleStep && autoMode && !stepTick && !doReturn |=>
      outFreq == $past(outFreq) + `STEP_MHZ && frequencyReadout == outFreq)
      else $error("single step not 1 MHz");
   return_start_a: assert property (
      doReturn |=> outFreq == $past(startSet) && !penLiftOe)
      else $error("return did not reload start");
   retrace_mark_a: assert property (
      $rose(penLiftOe) |-> $past(stepTick) && !penLiftOut)
      else $error("retrace marker without wrap");
   seg_test_a: assert property (
      btnSync.segTest |=> segAllOn)
      else $error("segment test not shown");
   ready_lamp_a: assert property (
      statSync == 2'h3 |=> lamps.lockGreen && lamps.levelGreen)
      else $error("ready lamps not green");
   mode_latch_a: assert property (
      press.slowSel && !press.fixedSel |=> activeMode == MODE_SLOW)
      else $error("slow mode not latched");
endmodule

/* File: bench/panel_operator.sv */
/*
 * Front panel operator model: buttons, settings, switches, loop status.
 * Assumes inputs change 1 ns after the rising clock edge.
 */
`timescale 1ns/1ps
module panel_operator (
   // Clock
   input wire logic clk,
   // Panel side
   output sweep_pkg::panel_btn_t buttons,
   output sweep_pkg::freq_t startSetting,
   output sweep_pkg::span_t spanSetting,
   output logic [4:0] addrSwitches,
   output logic lockAchieved,
   output logic levelAchieved
);
   import sweep_pkg::*;
   initial begin
      buttons = '0;
      startSetting = 15'h03e8;
      spanSetting = 14'h000a;
      addrSwitches = 5'h00;
      lockAchieved = 1'b0;
      levelAchieved = 1'b0;
   end
   // Settings kept below the 26 GHz ceiling
   task automatic setup(input freq_t st, input span_t sp);
      @(posedge clk);
      #1;
      if ({1'b0, st} + {2'b00, sp} < 16'h6590) begin
         startSetting = st;
         spanSetting = sp;
      end
   endtask
   // Button, switch and status levels, changed together off the edge
   task automatic levels(input panel_btn_t b, input logic [4:0] a,
                         input logic lk, input logic lv);
      @(posedge clk);
      #1;
      buttons = b;
      addrSwitches = a;
      lockAchieved = lk;
      levelAchieved = lv;
   endtask
   // One press: held 3 cycles, then released 3 cycles
   task automatic press(input panel_btn_t b);
      @(posedge clk);
      #1;
      buttons = b;
      repeat (3) @(posedge clk);
      #1;
      buttons = '0;
      repeat (3) @(posedge clk);
      #1;
   endtask
endmodule

/* File: bench/tb_stepped_sweep_controller.sv */
/*
 * Self-checking bench of the stepped sweep controller.
 * Assumes SLOW_DIV=20 and FAST_DIV=10 shortened step periods.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failCount++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb_stepped_sweep_controller;
   import sweep_pkg::*;
   localparam int SD = 20;
   localparam int FD = 10;
   localparam panel_btn_t FIX = 6'h20, SLW = 6'h10, FST = 6'h08;
   localparam panel_btn_t ONE = 6'h04, RET = 6'h02;
   logic clk = 1'b0, rst_n = 1'b0;
   panel_btn_t buttons;
   freq_t startSetting, outFreq, frequencyReadout;
   span_t spanSetting, rampValue;
   logic [4:0] addrSwitches, busAddress;
   logic lockAchieved, levelAchieved, segAllOn, penLiftOut, penLiftOe;
   mode_t activeMode;
   lamps_t lamps;
   int failCount = 0, checkCount = 0;
   always #2 clk = ~clk;
   panel_operator i_panel (.clk(clk), .buttons(buttons),
      .startSetting(startSetting), .spanSetting(spanSetting),
      .addrSwitches(addrSwitches), .lockAchieved(lockAchieved),
      .levelAchieved(levelAchieved));
   stepped_sweep_controller #(.SLOW_DIV(SD), .FAST_DIV(FD)) i_dut (
      .clk(clk), .rst_n(rst_n), .buttons(buttons),
      .startSetting(startSetting), .spanSetting(spanSetting),
      .addrSwitches(addrSwitches), .lockAchieved(lockAchieved),
      .levelAchieved(levelAchieved), .outFreq(outFreq),
      .frequencyReadout(frequencyReadout), .segAllOn(segAllOn),
      .activeMode(activeMode), .rampValue(rampValue),
      .penLiftOut(penLiftOut), .penLiftOe(penLiftOe), .lamps(lamps),
      .busAddress(busAddress));
   task automatic printVerdict();
      $display("checks %0d failures %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic waitStep(output int n);
      freq_t old;
      old = outFreq;
      n = 0;
      do begin @(posedge clk); #1; n++; end
      while (outFreq === old && n < 5000);
   endtask
   // Auto sweep: step spacing, top value, wrap, marker, period
   task automatic sweepCheck(input panel_btn_t b, input mode_t m,
                             input int div);
      int n;
      int k;
      freq_t prev;
      i_panel.press(b);
      `CHK(activeMode, m)
      waitStep(n);
      waitStep(n);
      `CHK(n, div)
      k = 0;
      do begin prev = outFreq; waitStep(n); k++; end
      while (penLiftOe !== 1'b1 && k < 20);
      `CHK(prev, freq_t'(16'h03f2))
      `CHK(outFreq, startSetting)
      `CHK(penLiftOut, 1'b0)
      n = 0;
      do begin @(posedge clk); #1; n++; end while (penLiftOe && n < 999);
      `CHK(n, div)
      waitStep(n);
      `CHK(rampValue, span_t'(outFreq - startSetting))
      // Count runs from end of retrace to the next retrace: span steps
      do begin @(posedge clk); #1; n++; end while (!penLiftOe && n < 999);
      `CHK(n, int'(spanSetting) * div)
   endtask
   // Entered during retrace: return must drop the marker at once
   task automatic manualCheck();
      int n;
      freq_t exp;
      i_panel.press(RET);
      `CHK(outFreq, startSetting)
      `CHK(penLiftOe, 1'b0)
      waitStep(n);
      exp = outFreq + 15'h0001;
      i_panel.press(ONE);
      `CHK(outFreq, exp)
      `CHK(frequencyReadout, exp)
   endtask
   task automatic fixedCheck();
      i_panel.press(FIX);
      `CHK(activeMode, MODE_FIXED)
      i_panel.setup(15'h0064, 14'h270f);
      repeat (6) @(posedge clk);
      #1;
      `CHK(outFreq, freq_t'(15'h0064))
      i_panel.press(ONE);
      `CHK(outFreq, freq_t'(15'h0064))
      `CHK(penLiftOe, 1'b0)
      i_panel.setup(15'h03e8, 14'h000a);
   endtask
   task automatic statusCheck();
      i_panel.levels(6'h01, 5'h15, 1'b1, 1'b1);
      repeat (5) @(posedge clk);
      #1;
      `CHK(segAllOn, 1'b1)
      `CHK(busAddress, 5'h15)
      `CHK(lamps, lamps_t'(2'h3))
      i_panel.levels('0, 5'h15, 1'b0, 1'b1);
      repeat (5) @(posedge clk);
      #1;
      `CHK(segAllOn, 1'b0)
      `CHK(lamps, lamps_t'(2'h1))
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      `CHK(activeMode, MODE_FIXED)
      fixedCheck();
      sweepCheck(SLW, MODE_SLOW, SD);
      manualCheck();
      sweepCheck(FST, MODE_FAST, FD);
      manualCheck();
      statusCheck();
      printVerdict();
   end
   initial begin
      #80000;
      failCount++;
      printVerdict();
   end
endmodule
